// *** verilog/ocd_pkg.sv ***
/*
 * Constants for the on-chip debug control block: debug port select
 * encodings, option word field positions, register offsets and layouts.
 * Assumes nothing of its surroundings.
 */
package ocd_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 32;
    // Option word zero and wake-up mask word field positions
    localparam int          OPT_SEL_HI_BIT = 30;
    localparam int          OPT_SEL_LO_BIT = 29;
    localparam int          WUF_DBG_BIT    = 31;
    // Register offsets (byte addresses)
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STAT       = 4'h4;
    localparam logic [3:0]  REG_IRQ_ST     = 4'h8;
    localparam logic [3:0]  REG_IRQ_MSK    = 4'hC;
    // Control bits
    localparam int          CTL_RT_PRIO    = 0;
    localparam int          CTL_FULL_STOP  = 1;
    localparam int          CTL_DELAY_STOP = 2;
    localparam int          CTL_POINT_MODE = 3;
    localparam int          CTL_FORCE_STOP = 4;
    localparam int          CTL_W          = 5;
    // Event bits and delay stop counter start value
    localparam int          EV_BREAK       = 0;
    localparam int          EV_TRACE_LOST  = 1;
    localparam int          EV_WAKE        = 2;
    localparam int          EV_W           = 3;
    localparam logic [7:0]  DELAY_RST      = 8'h10;

    typedef enum logic [1:0] {
        OCD_PORT_LINK4 = 2'b01,
        OCD_PORT_LINK1 = 2'b10,
        OCD_PORT_SCAN  = 2'b11,
        OCD_PORT_NONE  = 2'b00
    } ocd_port_t;

    typedef enum logic [1:0] {
        OCD_PWR_RUN     = 2'b00,
        OCD_PWR_STOP    = 2'b01,
        OCD_PWR_DEEP    = 2'b10,
        OCD_PWR_PERIOD  = 2'b11
    } ocd_pwr_t;
endpackage : ocd_pkg

// *** verilog/ocd_debug_ctrl.sv ***
/*
 * On-chip debug control: debug port selection from the option word,
 * pin dedication, break timing, trace gating and loss flag, standby
 * wake-up, register port and interrupt.
 * Assumes option word is stable at reset release and the CPU reports
 * break hits, instruction completion and trace requests as pulses.
 */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module ocd_debug_ctrl
(
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    // Nonvolatile option word and wake-up mask word
    input  wire logic [31:0]               option_word_zero,
    input  wire logic [31:0]               wakeup_factor_mask_word0,
    // Debug session present and pin mux request from application
    input  wire logic                      on_chip_debug,
    input  wire logic [3:0]                app_pin_out,
    input  wire logic [3:0]                app_pin_oe,
    input  wire logic [3:0]                dbg_pin_out,
    input  wire logic [3:0]                dbg_pin_oe,
    output logic [3:0]                     pin_out,
    output logic [3:0]                     pin_oe,
    output logic                           scan_port_en,
    output logic                           low_pin_debug_link_1,
    output logic                           low_pin_debug_link_4,
    // Break inputs from the comparators
    input  wire logic                      brk_data_hit,
    input  wire logic                      brk_exec_hit,
    input  wire logic                      insn_done,
    output logic                           break_req,
    // Trace path
    input  wire logic                      trc_fetch_start,
    input  wire logic                      trc_prev_valid,
    input  wire logic                      trc_addr_match,
    input  wire logic                      trc_data_match,
    input  wire logic                      trc_other_match,
    input  wire logic                      trc_msg,
    input  wire logic                      trc_fifo_busy,
    input  wire logic                      trc_mem_full,
    input  wire logic                      trc_event,
    input  wire logic                      dbg_mem_access,
    output logic                           trc_write,
    output logic                           trc_write_prev,
    output logic                           trc_stop,
    // Power state
    input  wire ocd_pkg::ocd_pwr_t         pwr_state,
    output logic                           wake_req,
    output logic                           iso_keep_power,
    // Register port
    input  wire logic [ocd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ocd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [ocd_pkg::DATA_W-1:0]     reg_rdata,
    output logic                           irq
);
    import ocd_pkg::*;
    ////////////////////////////////////////////////////////////////////
    ocd_port_t              port_q;
    logic                   sampled_q;
    logic [CTL_W-1:0]       ctrl_q;
    logic [EV_W-1:0]        ev_st_q;
    logic [EV_W-1:0]        ev_msk_q;
    logic                   data_brk_pend_q;
    logic [7:0]             delay_cnt_q;
    logic                   delay_arm_q;
    logic                   trc_stop_q;
    logic [DATA_W-1:0]      rdata_q;
    logic                   lost_ev;
    logic                   brk_ev;
    logic                   wake_ev;
    logic                   debug_on;
    logic                   full_stop_en;
    logic                   delay_stop_en;
    logic                   trc_hit;

    ////////////////////////////////////////////////////////////////////
    // Port select caught once after release; option word is
    // nonvolatile so its value after an aborted session is kept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            port_q    <= OCD_PORT_NONE;
            sampled_q <= 1'b0;
        end else if (!sampled_q) begin
            port_q    <= ocd_port_t'({option_word_zero[OPT_SEL_HI_BIT],
                                      option_word_zero[OPT_SEL_LO_BIT]});
            sampled_q <= 1'b1;
        end
    end

    assign scan_port_en         = port_q == OCD_PORT_SCAN;
    assign low_pin_debug_link_1 = port_q == OCD_PORT_LINK1;
    assign low_pin_debug_link_4 = port_q == OCD_PORT_LINK4;
    assign debug_on = on_chip_debug && port_q != OCD_PORT_NONE;

    // Application loses its pin functions while debugging
    assign pin_out = debug_on ? dbg_pin_out : app_pin_out;
    assign pin_oe  = debug_on ? dbg_pin_oe  : app_pin_oe;

    ////////////////////////////////////////////////////////////////////
    // Execution breaks fire at once; data breaks wait for completion
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            data_brk_pend_q <= 1'b0;
        end else if (insn_done) begin
            data_brk_pend_q <= 1'b0;
        end else if (brk_data_hit) begin
            data_brk_pend_q <= 1'b1;
        end
    end

    assign break_req = debug_on && (brk_exec_hit ||
                       (insn_done && (data_brk_pend_q || brk_data_hit)));
    assign brk_ev = break_req;

    ////////////////////////////////////////////////////////////////////
    // Point mode drops the data-value condition entirely
    assign trc_hit = ctrl_q[CTL_POINT_MODE] ?
                     (trc_addr_match && trc_other_match) :
                     (trc_addr_match && trc_data_match && trc_other_match);
    // Message dropped when the trace path is busy; cannot be replayed
    assign trc_write = debug_on && trc_hit && !trc_fifo_busy;
    assign lost_ev   = debug_on && trc_hit && trc_fifo_busy;
    // Prior instruction may ride along with a section start
    assign trc_write_prev = trc_write && trc_fetch_start
                            && trc_prev_valid;

    assign full_stop_en  = ctrl_q[CTL_RT_PRIO]
                           && ctrl_q[CTL_FULL_STOP];
    assign delay_stop_en = ctrl_q[CTL_RT_PRIO]
                           && ctrl_q[CTL_DELAY_STOP];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            delay_arm_q <= 1'b0;
            delay_cnt_q <= DELAY_RST;
        end else if (!delay_stop_en) begin
            delay_arm_q <= 1'b0;
            delay_cnt_q <= DELAY_RST;
        end else if (trc_event && !delay_arm_q) begin
            delay_arm_q <= 1'b1;
            delay_cnt_q <= DELAY_RST;
        end else if (delay_arm_q && trc_msg && delay_cnt_q != 8'h00) begin
            delay_cnt_q <= delay_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            trc_stop_q <= 1'b0;
        end else if (ctrl_q[CTL_FORCE_STOP]
                     || (full_stop_en && trc_mem_full)
                     || (delay_arm_q && delay_cnt_q == 8'h00)) begin
            trc_stop_q <= 1'b1;
        end else if (trc_event) begin
            trc_stop_q <= 1'b0;
        end
    end
    assign trc_stop = trc_stop_q;

    ////////////////////////////////////////////////////////////////////
    // Breaks, debug memory accesses, trace events and forced or enabled stops pull the part out of standby
    assign wake_ev = debug_on && pwr_state != OCD_PWR_RUN &&
                     (break_req || dbg_mem_access || ctrl_q[CTL_FORCE_STOP]
                      || trc_event || full_stop_en || delay_stop_en);
    assign wake_req = wake_ev;
    // Isolated domain left powered so RAM contents survive
    assign iso_keep_power = debug_on && pwr_state == OCD_PWR_DEEP;

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= '0;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= reg_wdata[CTL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ev_msk_q <= '0;
        end else if (reg_wr && reg_addr == REG_IRQ_MSK) begin
            ev_msk_q <= reg_wdata[EV_W-1:0];
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ev_st_q <= '0;
        end else begin
            ev_st_q <= (ev_st_q & ~((reg_wr && reg_addr == REG_IRQ_ST) ?
                        reg_wdata[EV_W-1:0] : {EV_W{1'b0}}))
                       | {wake_ev, lost_ev, brk_ev};
        end
    end

    // A set mask bit blocks its event from the line
    assign irq = |(ev_st_q & ~ev_msk_q);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:    rdata_q <= DATA_W'(ctrl_q);
                REG_STAT:    rdata_q <= DATA_W'({
                                 wakeup_factor_mask_word0[WUF_DBG_BIT],
                                 trc_stop_q, debug_on, 
                                 logic'(port_q[1]), logic'(port_q[0])});
                REG_IRQ_ST:  rdata_q <= DATA_W'(ev_st_q);
                REG_IRQ_MSK: rdata_q <= DATA_W'(ev_msk_q);
                default:     rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////
    property p_port_held;
        @(posedge clk_sys) disable iff (!nrst)
        sampled_q |=> $stable(port_q);
    endproperty
    a_port_held: assert property (p_port_held)
        else $error("port select changed after sampling");

    property p_exec_break;
        @(posedge clk_sys) disable iff (!nrst)
        (debug_on && brk_exec_hit) |-> break_req;
    endproperty
    a_exec_break: assert property (p_exec_break)
        else $error("execution break not immediate");

    property p_data_break_wait;
        @(posedge clk_sys) disable iff (!nrst)
        (brk_data_hit && !insn_done && !brk_exec_hit) |-> !break_req;
    endproperty
    a_data_break_wait: assert property (p_data_break_wait)
        else $error("data break fired before completion");

    property p_pins_dedicated;
        @(posedge clk_sys) disable iff (!nrst)
        debug_on |-> (pin_oe == dbg_pin_oe && pin_out == dbg_pin_out);
    endproperty
    a_pins_dedicated: assert property (p_pins_dedicated)
        else $error("debug pins not dedicated");

    property p_one_port;
        @(posedge clk_sys) disable iff (!nrst)
        $onehot0({scan_port_en, low_pin_debug_link_1,
                  low_pin_debug_link_4});
    endproperty
    a_one_port: assert property (p_one_port)
        else $error("more than one debug port enabled");

    property p_lost_flag;
        @(posedge clk_sys) disable iff (!nrst)
        lost_ev |=> ev_st_q[EV_TRACE_LOST];
    endproperty
    a_lost_flag: assert property (p_lost_flag)
        else $error("trace loss not flagged");

    property p_nrt_no_full_stop;
        @(posedge clk_sys) disable iff (!nrst)
        (!ctrl_q[CTL_RT_PRIO] && !ctrl_q[CTL_FORCE_STOP] && !trc_stop_q
         && !delay_arm_q) |=> !trc_stop_q;
    endproperty
    a_nrt_no_full_stop: assert property (p_nrt_no_full_stop)
        else $error("stop function active without realtime priority");

    property p_point_ignores_data;
        @(posedge clk_sys) disable iff (!nrst)
        (debug_on && ctrl_q[CTL_POINT_MODE] && trc_addr_match
         && trc_other_match && !trc_fifo_busy) |-> trc_write;
    endproperty
    a_point_ignores_data: assert property (p_point_ignores_data)
        else $error("point trace applied data condition");

    property p_wake_on_break;
        @(posedge clk_sys) disable iff (!nrst)
        (break_req && pwr_state != OCD_PWR_RUN) |-> wake_req;
    endproperty
    a_wake_on_break: assert property (p_wake_on_break)
        else $error("break did not wake from standby");

    property p_deep_powered;
        @(posedge clk_sys) disable iff (!nrst)
        (debug_on && pwr_state == OCD_PWR_DEEP) |-> iso_keep_power;
    endproperty
    a_deep_powered: assert property (p_deep_powered)
        else $error("isolated domain not kept powered");

    property p_sel_sampled;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(sampled_q) |->
            (port_q == $past({option_word_zero[OPT_SEL_HI_BIT],
                              option_word_zero[OPT_SEL_LO_BIT]}));
    endproperty
    a_sel_sampled: assert property (p_sel_sampled)
        else $error("port select not taken from option word");

    property p_wake_on_access;
        @(posedge clk_sys) disable iff (!nrst)
        (debug_on && dbg_mem_access && pwr_state != OCD_PWR_RUN) |-> wake_req;
    endproperty
    a_wake_on_access: assert property (p_wake_on_access)
        else $error("memory access did not wake from standby");

    property p_busy_no_write;
        @(posedge clk_sys) disable iff (!nrst)
        trc_fifo_busy |-> !trc_write;
    endproperty
    a_busy_no_write: assert property (p_busy_no_write)
        else $error("trace written while path busy");

    property p_delay_stop;
        @(posedge clk_sys) disable iff (!nrst)
        (delay_stop_en && delay_arm_q && delay_cnt_q == 8'h00) |=> trc_stop_q;
    endproperty
    a_delay_stop: assert property (p_delay_stop)
        else $error("delay stop did not stop trace");

    property p_prev_with_start;
        @(posedge clk_sys) disable iff (!nrst)
        (trc_write && trc_fetch_start && trc_prev_valid) |-> trc_write_prev;
    endproperty
    a_prev_with_start: assert property (p_prev_with_start)
        else $error("preceding instruction not traced at start");
endmodule : ocd_debug_ctrl

// *** tb/ocd_probe_model.sv ***
/* Debug probe model: owns the nonvolatile option word and the debug pins.
   Assumes one clock; the bench says when to connect, which link variant
   to use and whether to restore the scan port at session end. */
`timescale 1ns/10ps
module ocd_probe_model (
    input  wire logic        clk_sys,
    input  wire logic        connect,
    input  wire logic        one_pin,
    input  wire logic        restore_scan,
    output logic [31:0]      option_word_zero,
    output logic             on_chip_debug,
    output logic [3:0]       dbg_pin_out,
    output logic [3:0]       dbg_pin_oe
);
    initial begin
        // Blank part, select field reads 11
        option_word_zero = 32'h6000_0000;
        on_chip_debug    = 1'b0;
        dbg_pin_out      = 4'h5;
        dbg_pin_oe       = 4'h0;
    end
    always @(posedge clk_sys) begin
        // Link code is written once per connect; kept over power loss
        if (connect && !on_chip_debug) begin
            option_word_zero[30:29] <= one_pin ? 2'b10 : 2'b01;
        end
        // Scan code only by an explicit rewrite at session end
        if (!connect && on_chip_debug && restore_scan) begin
            option_word_zero[30:29] <= 2'b11;
        end
        on_chip_debug <= connect;
        // Released pins toggle so stale values cannot pass for driven ones
        dbg_pin_out   <= connect ? dbg_pin_out + 4'h1 : ~dbg_pin_out;
        dbg_pin_oe    <= {4{connect}};
    end
endmodule : ocd_probe_model

// *** tb/ocd_debug_ctrl_bench.sv ***
/* Directed bench for the on-chip debug control block.
   Assumes the probe model owns the option word and the debug pins. */
`timescale 1ns/10ps
module ocd_debug_ctrl_bench;
    import ocd_pkg::*;
    logic              clk_sys, nrst, connect, one_pin, restore_scan;
    logic [31:0]       option_word_zero, wakeup_factor_mask_word0;
    logic              on_chip_debug, scan_port_en, irq;
    logic [3:0]        app_pin_out, app_pin_oe, dbg_pin_out, dbg_pin_oe;
    logic [3:0]        pin_out, pin_oe;
    logic              low_pin_debug_link_1, low_pin_debug_link_4;
    logic              brk_data_hit, brk_exec_hit, insn_done, break_req;
    logic              trc_addr_match, trc_data_match, trc_other_match;
    logic              trc_msg, trc_fifo_busy, trc_mem_full, trc_event;
    logic              dbg_mem_access, trc_write, trc_stop, wake_req;
    logic              iso_keep_power, reg_wr, reg_rd;
    logic              trc_fetch_start, trc_prev_valid, trc_write_prev;
    ocd_pwr_t          pwr_state;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, d;
    int                fails, n_checks, cyc;

    ocd_probe_model probe (.clk_sys, .connect, .one_pin, .restore_scan,
        .option_word_zero, .on_chip_debug, .dbg_pin_out, .dbg_pin_oe);
    ocd_debug_ctrl dut (.clk_sys, .nrst, .option_word_zero,
        .wakeup_factor_mask_word0, .on_chip_debug, .app_pin_out,
        .app_pin_oe, .dbg_pin_out, .dbg_pin_oe, .pin_out, .pin_oe,
        .scan_port_en, .low_pin_debug_link_1, .low_pin_debug_link_4,
        .brk_data_hit, .brk_exec_hit, .insn_done, .break_req,
        .trc_fetch_start, .trc_prev_valid, .trc_addr_match,
        .trc_data_match, .trc_other_match, .trc_msg, .trc_fifo_busy,
        .trc_mem_full, .trc_event, .dbg_mem_access, .trc_write,
        .trc_write_prev, .trc_stop, .pwr_state, .wake_req,
        .iso_keep_power, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask : chk
    task tk(int n);
        repeat (n) @(posedge clk_sys);
    endtask : tk
    task do_rst;
        @(posedge clk_sys) nrst <= 1'b0;
        tk(16);
        nrst <= 1'b1;
        tk(2);
        #1;
    endtask : do_rst
    task wr(logic [3:0] a, logic [31:0] v);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rdc(string nm, logic [3:0] a, logic [31:0] e);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rdc
    task chp(logic [2:0] e);
        chk("ports", e, {scan_port_en, low_pin_debug_link_1,
            low_pin_debug_link_4});
    endtask : chp
    ////////////////////////////////////////////////////////////////////
    task t_port;
        do_rst;
        chp(3'b100);
        for (int i = 0; i < 2; i++) begin
            tk(1);
            {connect, one_pin} <= {1'b1, i[0]};
            tk(3);
            #1 chp(i ? 3'b001 : 3'b100);
            do_rst;
            chp(i ? 3'b010 : 3'b001);
            tk(1);
            {connect, restore_scan} <= {1'b0, i[0]};
            tk(3);
            do_rst;
            chp(i ? 3'b100 : 3'b001);
        end
        do_rst;
        chp(3'b100);
        tk(1);
        {connect, one_pin, restore_scan} <= 3'b100;
        tk(3);
        do_rst;
        rdc("stat", REG_STAT, 32'h05);
    endtask : t_port
    task t_pins;
        #1 chk("pin_out", dbg_pin_out, pin_out);
        chk("pin_oe", dbg_pin_oe, pin_oe);
        tk(1);
        connect <= 1'b0;
        tk(3);
        #1 chk("app_out", app_pin_out, pin_out);
        tk(1);
        connect <= 1'b1;
        tk(3);
    endtask : t_pins
    task t_break;
        brk_data_hit <= 1'b1;
        #1 chk("brk_early", 0, break_req);
        tk(1);
        brk_data_hit <= 1'b0;
        tk(1);
        insn_done <= 1'b1;
        #1 chk("brk_after", 1, break_req);
        tk(1);
        {insn_done, brk_exec_hit} <= 2'b01;
        #1 chk("brk_exec", 1, break_req);
        tk(1);
        brk_exec_hit <= 1'b0;
        wr(REG_IRQ_MSK, 32'h0);
        chk("irq_on", 1, irq);
        rdc("irq_st", REG_IRQ_ST, 32'h1);
        wr(REG_IRQ_MSK, 32'h1);
        chk("irq_mask", 0, irq);
        wr(REG_IRQ_MSK, 32'h0);
        wr(REG_IRQ_ST, 32'h1);
        chk("irq_clr", 0, irq);
        rdc("unmapped", 4'h2, 32'h0);
    endtask : t_break
    task t_wake;
        tk(1);
        for (int i = 0; i < 4; i++) begin
            pwr_state      <= ocd_pwr_t'(i);
            dbg_mem_access <= 1'b1;
            #1 chk("wake", i != 0, wake_req);
            if (i == 2) chk("iso", 1, iso_keep_power);
            tk(1);
        end
        dbg_mem_access <= 1'b0;
        tk(1);
        brk_exec_hit <= 1'b1;
        #1 chk("wake_brk", 1, wake_req);
        tk(1);
        brk_exec_hit <= 1'b0;
        pwr_state    <= OCD_PWR_RUN;
        rdc("irq_wake", REG_IRQ_ST, 32'h5);
        wr(REG_IRQ_ST, 32'h7);
    endtask : t_wake
    task t_trace;
        wr(REG_CTRL, 32'h09);
        tk(1);
        {trc_addr_match, trc_data_match, trc_other_match} <= 3'b101;
        {trc_fetch_start, trc_prev_valid} <= 2'b11;
        #1 chk("point", 1, trc_write);
        chk("prev", 1, trc_write_prev);
        tk(1);
        trc_other_match <= 1'b0;
        #1 chk("point_other", 0, trc_write);
        chk("prev_off", 0, trc_write_prev);
        tk(1);
        {trc_other_match, trc_fifo_busy} <= 2'b11;
        #1 chk("lost_wr", 0, trc_write);
        tk(1);
        {trc_addr_match, trc_fifo_busy} <= 2'b00;
        {trc_fetch_start, trc_prev_valid} <= 2'b00;
        rdc("lost", REG_IRQ_ST, 32'h2);
    endtask : t_trace
    task t_stop;
        for (int i = 0; i < 2; i++) begin
            wr(REG_CTRL, i ? 32'h03 : 32'h02);
            tk(1);
            trc_mem_full <= 1'b1;
            tk(1);
            trc_mem_full <= 1'b0;
            tk(2);
            #1 chk("full_stop", i, trc_stop);
        end
        wr(REG_CTRL, 32'h05);
        tk(1);
        trc_event <= 1'b1;
        tk(1);
        {trc_event, trc_msg} <= 2'b01;
        tk(15);
        trc_msg <= 1'b0;
        tk(2);
        #1 chk("delay_15", 0, trc_stop);
        tk(1);
        trc_msg <= 1'b1;
        tk(1);
        trc_msg <= 1'b0;
        tk(2);
        #1 chk("delay_16", 1, trc_stop);
    endtask : t_stop
    ////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        {nrst, connect, one_pin, restore_scan} = 4'h0;
        wakeup_factor_mask_word0 = 32'h0;
        {app_pin_out, app_pin_oe} = 8'hAF;
        {trc_fetch_start, trc_prev_valid} = 2'h0;
        {brk_data_hit, brk_exec_hit, insn_done, dbg_mem_access} = 4'h0;
        {trc_addr_match, trc_data_match, trc_other_match} = 3'h0;
        {trc_msg, trc_fifo_busy, trc_mem_full, trc_event} = 4'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 38'h0;
        pwr_state = OCD_PWR_RUN;
        t_port;
        t_pins;
        t_break;
        t_wake;
        t_trace;
        t_stop;
        give_verdict;
    end
endmodule : ocd_debug_ctrl_bench
